// >>> hdl/tic_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants for the interval timekeeper
// Assumes: registers sit on the core's special function register port
// Notes:   addresses are the raw register addresses of that port
//////////////////////////////////////////////////////////////////////////////
package tic_pkg;

  // register addresses
  localparam logic [7:0] ADDR_CONTROL   = 8'hA1;
  localparam logic [7:0] ADDR_SUBSECOND = 8'hA2;
  localparam logic [7:0] ADDR_SECONDS   = 8'hA3;
  localparam logic [7:0] ADDR_MINUTES   = 8'hA4;
  localparam logic [7:0] ADDR_HOURS     = 8'hA5;
  localparam logic [7:0] ADDR_TARGET    = 8'hA6;

  // control field positions
  localparam int BIT_TIME_CLOCK_EN  = 0;
  localparam int BIT_INTERVAL_EN    = 1;
  localparam int BIT_MATCH_FLAG     = 2;
  localparam int BIT_SINGLE_SHOT    = 3;
  localparam int BIT_TIMEBASE_LO    = 4;
  localparam int BIT_TIMEBASE_HI    = 5;
  localparam int BIT_TWENTY_FOUR    = 6;

  // reset values
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_TIME    = 8'h00;
  localparam logic [7:0] RESET_TARGET  = 8'h00;

  // timebase selections
  localparam logic [1:0] TB_TICK    = 2'h0;
  localparam logic [1:0] TB_SECONDS = 2'h1;
  localparam logic [1:0] TB_MINUTES = 2'h2;
  localparam logic [1:0] TB_HOURS   = 2'h3;

  // timing: crystal edges per 1/128 s tick
  localparam int XTAL_HZ        = 32768;
  localparam int TICKS_PER_SEC  = 128;
  localparam int XTAL_PER_TICK  = XTAL_HZ / TICKS_PER_SEC;
  localparam logic [6:0] SUBSECOND_MAX = 7'h7F;
  localparam logic [5:0] SIXTY_MAX     = 6'h3B;
  localparam logic [7:0] HOUR_MAX_24   = 8'h17;
  localparam logic [7:0] HOUR_MAX_FULL = 8'hFF;

  // service vector used by the core on wake and interrupt
  localparam logic [15:0] MATCH_VECTOR = 16'h0053;

endpackage

// >>> hdl/tic_xtal_sync.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: bring the crystal level into core_clk and mark its rising edges
// Assumes: crystal is far slower than core_clk
// Notes:   first flop feeds only the second flop
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module tic_xtal_sync
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // crystal level and its edge pulse
  input  wire logic xtal_in,
  output logic      xtal_rise
);

  logic meta;
  logic sync;
  logic sync_d;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta   <= 1'b0;
      sync   <= 1'b0;
      sync_d <= 1'b0;
    end
    else
    begin
      meta   <= xtal_in;
      sync   <= meta;
      sync_d <= sync;
    end
  end

  assign xtal_rise = sync & ~sync_d;

endmodule

// >>> hdl/tic_interval_timekeeper.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: time registers and 8-bit interval counter on crystal ticks
// Assumes: core interrupt enable and power-down state arrive as core_clk levels
// Notes:   register accesses are held and completed on a crystal edge
// Notes on behaviour
// - all timekeeping advances only on 32.768 kHz crystal edges, not core cycles.
// - intervals run from one 1/128 s tick up to 256 hours.
// - counting continues while the part is in power-down.
// - accesses complete on a crystal edge; software waits for busy to drop.
// - interval counter advances on each tick, second, minute or hour of the selected timebase.
// - counter equal to target sets match flag and requests interrupt if enabled.
// - in power-down with interrupt enabled, a set flag wakes the part.
// - time registers may be preloaded, then run on as a real-time clock.
// - six registers, the control register holds timebase, enables and flag.
// - timebase 00 tick, 01 seconds, 10 minutes, 11 hours.
// - single shot clears interval enable on match, else counter restarts.
// - time clock disable stops counting and restores last written time values.
// - subsecond counts 0 to 127, wraps and increments seconds.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module tic_interval_timekeeper
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // crystal pin
  input  wire logic       xtal_in,
  // register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_rd_done,
  output logic            sfr_busy,
  // core status
  input  wire logic       irq_enable,
  input  wire logic       power_down,
  output logic            irq_req,
  output logic            wake_req
);

  logic       xtal_tick;
  logic       pend_wr;
  logic       pend_rd;
  logic [7:0] pend_addr;
  logic [7:0] pend_data;
  logic       apply_wr;
  logic       apply_rd;
  logic [7:0] control;
  logic [7:0] target;
  logic [7:0] interval_count;
  logic [7:0] prescale;
  logic [6:0] subsecond_count;
  logic [5:0] seconds;
  logic [5:0] minutes;
  logic [7:0] hours;
  logic [6:0] shadow_sub;
  logic [5:0] shadow_sec;
  logic [5:0] shadow_min;
  logic [7:0] shadow_hour;
  logic       time_clock_enable;
  logic       tick128;
  logic       sub_ovf;
  logic       sec_ovf;
  logic       min_ovf;
  logic       sel_ovf;
  logic [7:0] next_count;
  logic       match_evt;
  logic [7:0] hour_max;

  function automatic logic hits(input logic [7:0] addr, input logic [7:0] reg_addr);
    hits = (addr == reg_addr);
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr >= tic_pkg::ADDR_CONTROL) && (addr <= tic_pkg::ADDR_TARGET);
  endfunction

  tic_xtal_sync tic_xtal_sync_inst
  (
    .core_clk  (core_clk),
    .rst       (rst),
    .xtal_in   (xtal_in),
    .xtal_rise (xtal_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // access handoff to crystal edges
  assign apply_wr = pend_wr & xtal_tick;
  assign apply_rd = pend_rd & xtal_tick;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pend_wr   <= 1'b0;
      pend_rd   <= 1'b0;
      pend_addr <= 8'h00;
      pend_data <= 8'h00;
    end
    else if ((sfr_wr || sfr_rd) && is_mapped(sfr_addr))
    begin
      pend_wr   <= sfr_wr;
      pend_rd   <= sfr_rd & ~sfr_wr;
      pend_addr <= sfr_addr;
      pend_data <= sfr_wdata;
    end
    else if (xtal_tick)
    begin
      pend_wr <= 1'b0;
      pend_rd <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sfr_rdata   <= 8'h00;
      sfr_rd_done <= 1'b0;
      sfr_busy    <= 1'b0;
    end
    else
    begin
      sfr_rd_done <= apply_rd;
      sfr_busy    <= (pend_wr | pend_rd) & ~xtal_tick;
      if (apply_rd)
      begin
        case (pend_addr)
          tic_pkg::ADDR_CONTROL:   sfr_rdata <= {1'b0, control[6:0]};
          tic_pkg::ADDR_SUBSECOND: sfr_rdata <= {1'b0, subsecond_count};
          tic_pkg::ADDR_SECONDS:   sfr_rdata <= {2'b00, seconds};
          tic_pkg::ADDR_MINUTES:   sfr_rdata <= {2'b00, minutes};
          tic_pkg::ADDR_HOURS:     sfr_rdata <= hours;
          tic_pkg::ADDR_TARGET:    sfr_rdata <= target;
          default:                 sfr_rdata <= 8'h00;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // time chain
  assign time_clock_enable     = control[tic_pkg::BIT_TIME_CLOCK_EN];
  assign tick128  = xtal_tick & time_clock_enable & (prescale == 8'(tic_pkg::XTAL_PER_TICK - 1));
  assign sub_ovf  = tick128 & (subsecond_count == tic_pkg::SUBSECOND_MAX);
  assign sec_ovf  = sub_ovf & (seconds == tic_pkg::SIXTY_MAX);
  assign min_ovf  = sec_ovf & (minutes == tic_pkg::SIXTY_MAX);
  assign hour_max = control[tic_pkg::BIT_TWENTY_FOUR] ? tic_pkg::HOUR_MAX_24 : tic_pkg::HOUR_MAX_FULL;

  always_ff @(posedge core_clk)
  begin
    if (rst || !time_clock_enable)
      prescale <= 8'h00;
    else if (xtal_tick)
      prescale <= prescale + 8'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      subsecond_count <= tic_pkg::RESET_TIME[6:0];
      seconds         <= tic_pkg::RESET_TIME[5:0];
      minutes         <= tic_pkg::RESET_TIME[5:0];
      hours           <= tic_pkg::RESET_TIME;
      shadow_sub      <= tic_pkg::RESET_TIME[6:0];
      shadow_sec      <= tic_pkg::RESET_TIME[5:0];
      shadow_min      <= tic_pkg::RESET_TIME[5:0];
      shadow_hour     <= tic_pkg::RESET_TIME;
    end
    else if (apply_wr && !hits(pend_addr, tic_pkg::ADDR_CONTROL) && !hits(pend_addr, tic_pkg::ADDR_TARGET))
    begin
      case (pend_addr)
        tic_pkg::ADDR_SUBSECOND:
        begin
          subsecond_count <= pend_data[6:0];
          shadow_sub      <= pend_data[6:0];
        end
        tic_pkg::ADDR_SECONDS:
        begin
          seconds    <= pend_data[5:0];
          shadow_sec <= pend_data[5:0];
        end
        tic_pkg::ADDR_MINUTES:
        begin
          minutes    <= pend_data[5:0];
          shadow_min <= pend_data[5:0];
        end
        default:
        begin
          hours       <= pend_data;
          shadow_hour <= pend_data;
        end
      endcase
    end
    else if (!time_clock_enable)
    begin
      subsecond_count <= shadow_sub;
      seconds         <= shadow_sec;
      minutes         <= shadow_min;
      hours           <= shadow_hour;
    end
    else if (tick128)
    begin
      subsecond_count <= sub_ovf ? 7'h00 : subsecond_count + 7'h01;
      if (sub_ovf)
        seconds <= sec_ovf ? 6'h00 : seconds + 6'h01;
      if (sec_ovf)
        minutes <= min_ovf ? 6'h00 : minutes + 6'h01;
      if (min_ovf)
        hours <= (hours >= hour_max) ? 8'h00 : hours + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interval counter and control
  always_comb
  begin
    case (control[tic_pkg::BIT_TIMEBASE_HI:tic_pkg::BIT_TIMEBASE_LO])
      tic_pkg::TB_TICK:    sel_ovf = tick128;
      tic_pkg::TB_SECONDS: sel_ovf = sub_ovf;
      tic_pkg::TB_MINUTES: sel_ovf = sec_ovf;
      tic_pkg::TB_HOURS:   sel_ovf = min_ovf;
      default:             sel_ovf = 1'b0;
    endcase
  end

  assign next_count = interval_count + 8'h01;
  assign match_evt  = control[tic_pkg::BIT_INTERVAL_EN] & sel_ovf & (next_count == target);

  always_ff @(posedge core_clk)
  begin
    if (rst || !control[tic_pkg::BIT_INTERVAL_EN])
      interval_count <= 8'h00;
    else if (match_evt)
      interval_count <= 8'h00;
    else if (sel_ovf)
      interval_count <= next_count;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      target <= tic_pkg::RESET_TARGET;
    else if (apply_wr && hits(pend_addr, tic_pkg::ADDR_TARGET))
      target <= pend_data;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      control <= tic_pkg::RESET_CONTROL;
    else
    begin
      if (apply_wr && hits(pend_addr, tic_pkg::ADDR_CONTROL))
        control <= {1'b0, pend_data[6:0]};
      if (match_evt)
      begin
        control[tic_pkg::BIT_MATCH_FLAG] <= 1'b1;
        if (control[tic_pkg::BIT_SINGLE_SHOT])
          control[tic_pkg::BIT_INTERVAL_EN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_req  <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      irq_req  <= control[tic_pkg::BIT_MATCH_FLAG] & irq_enable;
      wake_req <= control[tic_pkg::BIT_MATCH_FLAG] & irq_enable & power_down;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_sub_wrap;
    @(posedge core_clk) disable iff (rst)
    (sub_ovf && !apply_wr) |=> (subsecond_count == 7'h00) && (seconds == 6'(($past(seconds) + 6'h01) % 6'd60));
  endproperty
  a_sub_wrap: assert property (p_sub_wrap) else $error("subsecond wrap wrong");

  property p_sec_wrap;
    @(posedge core_clk) disable iff (rst)
    (sec_ovf && !apply_wr) |=> (seconds == 6'h00);
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds wrap wrong");

  property p_flag_sticky;
    @(posedge core_clk) disable iff (rst)
    (control[tic_pkg::BIT_MATCH_FLAG] && !apply_wr) |=> control[tic_pkg::BIT_MATCH_FLAG];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("match flag lost");

  property p_match_sets;
    @(posedge core_clk) disable iff (rst)
    match_evt |=> control[tic_pkg::BIT_MATCH_FLAG] ##1 (irq_req == irq_enable);
  endproperty
  a_match_sets: assert property (p_match_sets) else $error("match did not flag");

  property p_single_shot;
    @(posedge core_clk) disable iff (rst)
    (match_evt && control[tic_pkg::BIT_SINGLE_SHOT]) |=> !control[tic_pkg::BIT_INTERVAL_EN];
  endproperty
  a_single_shot: assert property (p_single_shot) else $error("single shot kept running");

  property p_restore;
    @(posedge core_clk) disable iff (rst)
    (!time_clock_enable && !apply_wr) |=> (subsecond_count == shadow_sub) && (hours == shadow_hour);
  endproperty
  a_restore: assert property (p_restore) else $error("time not restored");

  property p_wake;
    @(posedge core_clk) disable iff (rst)
    (control[tic_pkg::BIT_MATCH_FLAG] && irq_enable && power_down) |=> wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_write_held;
    @(posedge core_clk) disable iff (rst)
    (pend_wr && !xtal_tick && !sfr_wr && !sfr_rd && !match_evt) |=> pend_wr && $stable(control);
  endproperty
  a_write_held: assert property (p_write_held) else $error("write applied off crystal edge");

  property p_count_adv;
    @(posedge core_clk) disable iff (rst)
    (control[tic_pkg::BIT_INTERVAL_EN] && sel_ovf && !match_evt && !apply_wr) |=> interval_count == $past(next_count);
  endproperty
  a_count_adv: assert property (p_count_adv) else $error("interval count stalled");

  property p_no_core_tick;
    @(posedge core_clk) disable iff (rst)
    !xtal_tick |=> $stable(prescale) || (prescale == 8'h00);
  endproperty
  a_no_core_tick: assert property (p_no_core_tick) else $error("prescaler moved without crystal");

  c_match:      cover property (@(posedge core_clk) disable iff (rst) match_evt);
  c_single:     cover property (@(posedge core_clk) disable iff (rst) match_evt && control[tic_pkg::BIT_SINGLE_SHOT]);
  c_wake:       cover property (@(posedge core_clk) disable iff (rst) wake_req);
  c_minute_ovf: cover property (@(posedge core_clk) disable iff (rst) sec_ovf);

endmodule

// >>> bench/tb_time_interval_counter.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench for the interval timekeeper
// Assumes: crystal modelled at 25 MHz so one 1/128 s tick is 2048 core cycles
// Notes:   long timebases are reached by preloading the time registers
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module tb_time_interval_counter;
  logic       core_clk;
  logic       rst;
  logic       xtal_in;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       sfr_rd_done;
  logic       sfr_busy;
  logic       irq_enable;
  logic       power_down;
  logic       irq_req;
  logic       wake_req;
  int         bad_count;
  int         n_tests;

  tic_interval_timekeeper tic_interval_timekeeper_inst
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .xtal_in     (xtal_in),
    .sfr_addr    (sfr_addr),
    .sfr_wr      (sfr_wr),
    .sfr_rd      (sfr_rd),
    .sfr_wdata   (sfr_wdata),
    .sfr_rdata   (sfr_rdata),
    .sfr_rd_done (sfr_rd_done),
    .sfr_busy    (sfr_busy),
    .irq_enable  (irq_enable),
    .power_down  (power_down),
    .irq_req     (irq_req),
    .wake_req    (wake_req)
  );

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // crystal runs free, phase unrelated to core_clk
  initial
  begin
    xtal_in = 1'b0;
    #3.3;
    forever #20 xtal_in = ~xtal_in;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  // busy is registered from the pending flag, so it is first meaningful one cycle after the request
  task automatic wait_idle();
    int n;
    n = 0;
    tick();
    while (sfr_busy !== 1'b0 && n < 7000)
    begin
      tick();
      n++;
    end
    chk("access latency", 8'h01, {7'h0, n < 10});
    chk("access finished", 8'h01, {7'h0, n < 7000});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    tick();
    sfr_wr = 1'b0;
    wait_idle();
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    int n;
    n        = 0;
    sfr_addr = a;
    sfr_rd   = 1'b1;
    tick();
    sfr_rd = 1'b0;
    while (sfr_rd_done !== 1'b1 && n < 7000)
    begin
      tick();
      n++;
    end
    chk(what, exp, sfr_rdata);
    tick();
  endtask

  // cycles until irq_req rises, capped at lim
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (irq_req !== 1'b1 && n < lim)
    begin
      tick();
      n++;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    chk("irq_req", 8'h00, {7'h0, irq_req});
    rd_chk("control", tic_pkg::ADDR_CONTROL, tic_pkg::RESET_CONTROL);
    rd_chk("subsecond", tic_pkg::ADDR_SUBSECOND, tic_pkg::RESET_TIME);
    rd_chk("seconds", tic_pkg::ADDR_SECONDS, tic_pkg::RESET_TIME);
    rd_chk("minutes", tic_pkg::ADDR_MINUTES, tic_pkg::RESET_TIME);
    rd_chk("hours", tic_pkg::ADDR_HOURS, tic_pkg::RESET_TIME);
    rd_chk("target", tic_pkg::ADDR_TARGET, tic_pkg::RESET_TARGET);
  endtask

  task automatic t_access();
    sfr_addr  = 8'hA7;
    sfr_wdata = 8'h5A;
    sfr_wr    = 1'b1;
    tick();
    sfr_wr = 1'b0;
    tick();
    chk("busy on unmapped", 8'h00, {7'h0, sfr_busy});
    wr(tic_pkg::ADDR_TARGET, 8'hC3);
    rd_chk("target", tic_pkg::ADDR_TARGET, 8'hC3);
    wr(tic_pkg::ADDR_CONTROL, 8'h80);
    rd_chk("control bit7", tic_pkg::ADDR_CONTROL, 8'h00);
  endtask

  // preload then let one tick carry through every register
  task automatic t_rollover();
    wr(tic_pkg::ADDR_SUBSECOND, 8'h7F);
    wr(tic_pkg::ADDR_SECONDS, 8'h3B);
    wr(tic_pkg::ADDR_MINUTES, 8'h3B);
    wr(tic_pkg::ADDR_CONTROL, 8'h01);
    repeat (2200) tick();
    rd_chk("hours", tic_pkg::ADDR_HOURS, 8'h01);
    rd_chk("minutes", tic_pkg::ADDR_MINUTES, 8'h00);
    rd_chk("seconds", tic_pkg::ADDR_SECONDS, 8'h00);
    rd_chk("subsecond", tic_pkg::ADDR_SUBSECOND, 8'h00);
    wr(tic_pkg::ADDR_CONTROL, 8'h00);
    rd_chk("restored subsecond", tic_pkg::ADDR_SUBSECOND, 8'h7F);
    rd_chk("restored seconds", tic_pkg::ADDR_SECONDS, 8'h3B);
    wr(tic_pkg::ADDR_MINUTES, 8'h3B);
    wr(tic_pkg::ADDR_HOURS, 8'h17);
    wr(tic_pkg::ADDR_CONTROL, 8'h41);
    repeat (2200) tick();
    rd_chk("hours 24h wrap", tic_pkg::ADDR_HOURS, 8'h00);
    wr(tic_pkg::ADDR_CONTROL, 8'h00);
  endtask

  task automatic t_single_shot();
    int n;
    wr(tic_pkg::ADDR_SUBSECOND, 8'h00);
    wr(tic_pkg::ADDR_TARGET, 8'h02);
    power_down = 1'b1;
    wr(tic_pkg::ADDR_CONTROL, 8'h0B);
    wait_irq(6000, n);
    chk("two tick match", 8'h01, {7'h0, n > 3800 && n < 4600});
    chk("wake_req", 8'h01, {7'h0, wake_req});
    rd_chk("control after match", tic_pkg::ADDR_CONTROL, 8'h0D);
    irq_enable = 1'b0;
    repeat (2) tick();
    chk("irq masked", 8'h00, {7'h0, irq_req});
    chk("wake masked", 8'h00, {7'h0, wake_req});
    irq_enable = 1'b1;
    power_down = 1'b0;
    repeat (2) tick();
    chk("irq again", 8'h01, {7'h0, irq_req});
    chk("wake awake", 8'h00, {7'h0, wake_req});
    wr(tic_pkg::ADDR_CONTROL, 8'h01);
    repeat (2) tick();
    chk("irq cleared", 8'h00, {7'h0, irq_req});
    wr(tic_pkg::ADDR_CONTROL, 8'h00);
  endtask

  // each wider timebase overflows after eight ticks from this preload
  task automatic t_timebases();
    int n;
    logic [7:0] ctl;
    for (int tb = 1; tb < 4; tb++)
    begin
      ctl = 8'h03 | (8'(tb) << 4);
      wr(tic_pkg::ADDR_SUBSECOND, 8'h78);
      wr(tic_pkg::ADDR_SECONDS, 8'h3B);
      wr(tic_pkg::ADDR_MINUTES, 8'h3B);
      wr(tic_pkg::ADDR_TARGET, 8'h01);
      wr(tic_pkg::ADDR_CONTROL, ctl);
      wait_irq(20000, n);
      chk("selected overflow", 8'h01, {7'h0, n > 15000 && n < 18000});
      rd_chk("control repeat", tic_pkg::ADDR_CONTROL, ctl | 8'h04);
      wr(tic_pkg::ADDR_CONTROL, 8'h00);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    bad_count  = 0;
    n_tests    = 0;
    rst        = 1'b1;
    sfr_addr   = 8'h00;
    sfr_wr     = 1'b0;
    sfr_rd     = 1'b0;
    sfr_wdata  = 8'h00;
    irq_enable = 1'b1;
    power_down = 1'b0;
    repeat (16) tick();
    rst = 1'b0;
    t_reset_values();
    t_access();
    t_rollover();
    t_single_shot();
    t_timebases();
    tally_and_finish();
  end

  // bounds a hang well beyond the expected run length
  initial
  begin
    repeat (90000) @(posedge core_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule
